// File: rtl/dee_arr_if.sv
// port bundle between the controller and the eeprom word array
// assumes one write port and one asynchronous read port
`default_nettype none

interface dee_arr_if;
  import dee_pkg::*;
  logic we;
  logic [IDX_W-1:0] widx;
  logic [IDX_W-1:0] ridx;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, widx, ridx, wdata, input rdata);
  modport mem (input we, widx, ridx, wdata, output rdata);
endinterface : dee_arr_if

`default_nettype wire

// File: rtl/dee_array.sv
// flip-flop model of the 16-bit data eeprom word array
// assumes the controller serialises writes, one word per cycle
`default_nettype none

module dee_array
  import dee_pkg::*;
#(
  parameter int WORDS = EE_WORDS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  dee_arr_if.mem arr
);

  logic [DATA_W-1:0] mem_q [WORDS];

  // [R17] 256-word array
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= ERASED;
      end
    end else if (arr.we) begin
      mem_q[arr.widx] <= arr.wdata;
    end
  end

  assign arr.rdata = mem_q[arr.ridx];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  word_store_a: assert property ( // [R17]
    arr.we |=> mem_q[$past(arr.widx)] == $past(arr.wdata))
    else $error("array word not stored");

endmodule : dee_array

`default_nettype wire

// File: rtl/dee_ctrl.sv
// data eeprom program/erase controller with apb register access
// assumes apb master on core_clk; reset and watchdog pins are asynchronous
//
// Our own choices: register access over APB and the register offsets.
`default_nettype none

// Overview of operation
// [R1] software writes 55h then AAh to key
// [R2] unlock permits one following control write only
// [R3] key register is write-only, reads zero
// [R4] go starts cycle, hardware alone clears it
// [R5] permit gates operations, cleared at finish
// [R6] reset or watchdog mid-cycle sets abort
// [R7] skip bit omits automatic erase before write
// [R8] erase select chooses erase or write
// [R9] codes erase eight, four or one word
// [R10] 0100xx bulk erases whole array
// [R11] 0010xx programs one latched word
// [R12] table write forms 24-bit capture address
// [R13] address captures are not software visible
// [R14] low capture bit zero always
// [R15] high capture top bit zero always
// [R16] array spans 7FFE00h to 7FFFFFh
// [R17] array holds 256 sixteen-bit words
// [R18] bus never stalls during a cycle
// [R19] only the low 16 data bits count
// [R20] software avoids reads during a cycle
// [R21] finish sets done flag, clears go
// [R22] software masks interrupts around unlock
// [R23] software issues two no-ops after go
// [R24] go without unlock starts nothing
module dee_ctrl
  import dee_pkg::*;
#(
  parameter int ERS_CYC = ERS_CYC_DEF,
  parameter int PGM_CYC = PGM_CYC_DEF,
  parameter int WORDS = EE_WORDS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_rst,
  output logic nv_done_irq_flag
);

  ////////////////////////////////////////////////////////////////////////////

  logic access;
  logic wr;
  logic setup_rd;
  logic a_ctrl;
  logic a_key;
  logic a_page;
  logic a_tofs;
  logic a_twr;
  logic a_trd;
  logic a_stat;
  logic mapped;
  logic ctrl_wr;
  logic unlocked;
  logic start;
  logic idle;
  logic busy;
  logic fin;
  logic abort_evt;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  logic go_q;
  logic permit_q;
  logic abort_q;
  logic skip_q;
  logic erase_q;
  logic [5:0] op_q;
  logic done_q;
  logic [7:0] page_q;
  logic [15:0] tofs_q;
  logic [7:0] ahi_q;
  logic [15:0] alo_q;
  logic [DATA_W-1:0] latch_q;
  logic [1:0] rs_meta_q;
  logic [1:0] rs_sync_q;

  dee_state_t st_q;
  logic [15:0] tmr_q;
  logic [8:0] cnt_q;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] base_q;
  logic in_rng_q;
  logic is_wr_q;

  logic [5:0] w_op;
  logic w_erase;
  logic w_skip;
  logic w_bulk;
  logic w_pgm;
  logic [8:0] w_n;
  logic [23:0] cap_addr;
  logic [23:0] tbl_addr;

  dee_arr_if arr_if ();

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  // [R18] zero wait states, even mid-cycle
  assign pready = 1'b1;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  assign a_ctrl = (paddr == OFS_CTRL);
  assign a_key = (paddr == OFS_KEY);
  assign a_page = (paddr == OFS_PAGE);
  assign a_tofs = (paddr == OFS_TOFS);
  assign a_twr = (paddr == OFS_TWR);
  assign a_trd = (paddr == OFS_TRD);
  assign a_stat = (paddr == OFS_STAT);
  assign mapped = a_ctrl || a_key || a_page || a_tofs || a_twr || a_trd ||
                  a_stat;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  assign idle = (st_q == ST_IDLE);
  assign busy = !idle;
  assign fin = (st_q == ST_FIN);
  assign ctrl_wr = wr && a_ctrl;

  dee_unlock u_unlock (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .access(access),
    .key_wr(wr && a_key),
    .key_val(pwdata[7:0]),
    .unlocked(unlocked)
  );

  // [R24] go honoured only straight after unlock
  assign start = ctrl_wr && unlocked && pwdata[B_GO] && pwdata[B_PERMIT] &&
                 idle;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux[15:0] = {go_q, permit_q, abort_q, skip_q, 5'h00,
                                erase_q, op_q};
      // [R3] key reads back as zero
      OFS_KEY: rd_mux = 32'h0000_0000;
      OFS_PAGE: rd_mux[7:0] = page_q;
      OFS_TOFS: rd_mux[15:0] = tofs_q;
      OFS_TWR: rd_mux[15:0] = latch_q;
      // [R20] undefined while busy; array port is taken
      OFS_TRD: rd_mux[15:0] = arr_if.rdata;
      OFS_STAT: rd_mux[1:0] = {busy, done_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // data is sampled in setup so it is steady in the access phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset-source synchronisers

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_meta_q <= 2'h0;
      rs_sync_q <= 2'h0;
    end else begin
      rs_meta_q <= {!external_reset_pin_n, watchdog_rst};
      rs_sync_q <= rs_meta_q;
    end
  end

  // [R6] only a cycle in flight is aborted
  assign abort_evt = busy && (rs_sync_q != 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      go_q <= 1'b0;
      permit_q <= 1'b0;
      abort_q <= 1'b0;
      skip_q <= 1'b0;
      erase_q <= 1'b0;
      op_q <= 6'h00;
    end else if (abort_evt) begin
      // [R6] abort flag set on cut-short cycle
      go_q <= 1'b0;
      permit_q <= 1'b0;
      abort_q <= 1'b1;
    end else if (fin) begin
      // [R5] permit dropped when cycle ends
      go_q <= 1'b0;
      permit_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (ctrl_wr && idle) begin
      // [R4] software can only set go
      go_q <= start;
      permit_q <= pwdata[B_PERMIT];
      abort_q <= pwdata[B_ABORT];
      skip_q <= pwdata[B_SKIP];
      erase_q <= pwdata[B_ERASE];
      op_q <= pwdata[B_OP_MSB:0];
    end
  end

  // [R21] completion flag, set beats clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (fin) begin
      done_q <= 1'b1;
    end else if (wr && a_stat && pwdata[B_DONE]) begin
      done_q <= 1'b0;
    end
  end

  assign nv_done_irq_flag = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // table pointer and address capture

  // [R13] captures have no bus address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= 8'h00;
      tofs_q <= 16'h0000;
      ahi_q <= 8'h00;
      alo_q <= 16'h0000;
      latch_q <= ERASED;
    end else if (wr) begin
      if (a_page) begin
        page_q <= pwdata[7:0];
      end
      if (a_tofs) begin
        tofs_q <= pwdata[15:0];
      end
      if (a_twr && idle) begin
        // [R12] capture from last table write
        // [R15] top bit of high capture forced low
        ahi_q <= {1'b0, page_q[6:0]};
        // [R14] word-even low capture
        alo_q <= {tofs_q[15:1], 1'b0};
        // [R19] upper half of the bus word ignored
        latch_q <= pwdata[DATA_W-1:0];
      end
    end
  end

  assign cap_addr = {ahi_q, alo_q};
  assign tbl_addr = {page_q, tofs_q};

  ////////////////////////////////////////////////////////////////////////////
  // operation decode

  assign w_op = pwdata[B_OP_MSB:0];
  assign w_erase = pwdata[B_ERASE];
  assign w_skip = pwdata[B_SKIP];
  // [R10] bulk erase ignores the captured address
  assign w_bulk = w_erase && (w_op[5:2] == OP_BULK_TOP);
  // [R11] single-word program
  assign w_pgm = !w_erase && (w_op[5:2] == OP_PGM_TOP);

  // [R9] word counts of partial erase
  always_comb begin
    w_n = 9'h000;
    if (w_bulk) begin
      w_n = N_BULK;
    end else if (w_pgm) begin
      w_n = N_ONE;
    end else if (w_erase) begin
      case (w_op)
        OP_ERS8: w_n = N_EIGHT;
        OP_ERS4: w_n = N_FOUR;
        OP_ERS1: w_n = N_ONE;
        default: w_n = 9'h000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  // [R18] runs beside the bus, cpu keeps going
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      tmr_q <= 16'h0000;
      cnt_q <= 9'h000;
      idx_q <= 8'h00;
      base_q <= 8'h00;
      in_rng_q <= 1'b0;
      is_wr_q <= 1'b0;
    end else if (abort_evt) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            cnt_q <= w_n;
            is_wr_q <= w_pgm;
            base_q <= cap_addr[IDX_W:1];
            idx_q <= w_bulk ? 8'h00 : cap_addr[IDX_W:1];
            // [R16] word ops outside the window change nothing
            in_rng_q <= w_bulk ||
                        (cap_addr >= EE_BASE && cap_addr <= EE_LAST);
            // [R8] erase select picks the path
            // [R7] pre-erase unless skip is set
            if (w_n == 9'h000) begin
              st_q <= ST_FIN;
            end else if (w_pgm && w_skip) begin
              tmr_q <= 16'(PGM_CYC - 1);
              st_q <= ST_PGM_WAIT;
            end else begin
              tmr_q <= 16'(ERS_CYC - 1);
              st_q <= ST_ERS_WAIT;
            end
          end
        end
        ST_ERS_WAIT: begin
          tmr_q <= tmr_q - 16'h0001;
          if (tmr_q == 16'h0000) begin
            st_q <= ST_ERS_SWEEP;
          end
        end
        ST_ERS_SWEEP: begin
          // one word per cycle; wraps at the top of the array
          idx_q <= idx_q + 8'h01;
          cnt_q <= cnt_q - 9'h001;
          if (cnt_q == N_ONE) begin
            tmr_q <= 16'(PGM_CYC - 1);
            st_q <= is_wr_q ? ST_PGM_WAIT : ST_FIN;
          end
        end
        ST_PGM_WAIT: begin
          tmr_q <= tmr_q - 16'h0001;
          if (tmr_q == 16'h0000) begin
            st_q <= ST_PGM_WR;
          end
        end
        ST_PGM_WR: st_q <= ST_FIN;
        ST_FIN: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array port

  // programming only clears bits, as the cells would without erase
  assign arr_if.we = in_rng_q &&
                     ((st_q == ST_ERS_SWEEP) || (st_q == ST_PGM_WR));
  assign arr_if.widx = (st_q == ST_ERS_SWEEP) ? idx_q : base_q;
  assign arr_if.wdata = (st_q == ST_ERS_SWEEP) ? ERASED :
                        (arr_if.rdata & latch_q);
  assign arr_if.ridx = busy ? base_q : tbl_addr[IDX_W:1];

  dee_array #(
    .WORDS(WORDS)
  ) u_array (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .arr(arr_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_start_wr;
    start && w_pgm;
  endsequence

  key_read_a: assert property ( // [R3]
    setup_rd && a_key |=> prdata == 32'h0000_0000)
    else $error("key register read non-zero");
  go_lock_a: assert property ( // [R24]
    $rose(go_q) |-> $past(unlocked && ctrl_wr))
    else $error("go set without unlock");
  go_hold_a: assert property ( // [R4]
    go_q && !fin && !abort_evt |=> go_q)
    else $error("go cleared before finish");
  fin_clear_a: assert property ( // [R5]
    fin && !abort_evt |=> !go_q && !permit_q && !abort_q)
    else $error("finish left go, permit or abort set");
  done_set_a: assert property ( // [R21]
    fin |=> done_q && idle)
    else $error("done flag not raised at finish");
  abort_set_a: assert property ( // [R6]
    abort_evt |=> abort_q && idle && !go_q)
    else $error("abort not recorded");
  pre_erase_a: assert property ( // [R7]
    s_start_wr |=> (st_q == ST_ERS_WAIT) == !$past(w_skip))
    else $error("pre-erase choice wrong");
  sel_path_a: assert property ( // [R8]
    start && !w_erase && !w_pgm |=> fin)
    else $error("unknown write code did not finish at once");
  ers8_cnt_a: assert property ( // [R9]
    start && w_erase && w_op == OP_ERS8 |=> cnt_q == N_EIGHT)
    else $error("eight-word erase count wrong");
  bulk_a: assert property ( // [R10]
    start && w_bulk |=> cnt_q == N_BULK && idx_q == 8'h00 && in_rng_q)
    else $error("bulk erase setup wrong");
  pgm_word_a: assert property ( // [R11]
    st_q == ST_PGM_WR && in_rng_q |-> arr_if.we && arr_if.widx == base_q)
    else $error("program word not written");
  capture_a: assert property ( // [R12]
    wr && a_twr && idle |=> cap_addr[22:1] == $past(tbl_addr[22:1]))
    else $error("address capture mismatch");
  lsb_zero_a: assert property (alo_q[0] == 1'b0) // [R14]
    else $error("low capture odd");
  msb_zero_a: assert property (ahi_q[7] == 1'b0) // [R15]
    else $error("high capture top bit set");
  range_a: assert property ( // [R16]
    st_q == ST_PGM_WR && !(cap_addr >= EE_BASE && cap_addr <= EE_LAST) |->
    !arr_if.we)
    else $error("write outside the eeprom window");
  no_stall_a: assert property ( // [R18]
    busy && wr && a_page |=> page_q == $past(pwdata[7:0]))
    else $error("register write lost during a cycle");

endmodule : dee_ctrl

`default_nettype wire

// File: rtl/dee_pkg.sv
// shared constants and types of the data eeprom program/erase controller
// assumes a 40 MHz core clock and an apb register bus with 32-bit data
`default_nettype none

package dee_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int ERS_TIME_NS = 4000;
  localparam int PGM_TIME_NS = 4000;
  // least times, so round up to whole cycles
  localparam int ERS_CYC_DEF =
    (ERS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PGM_CYC_DEF =
    (PGM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 12;
  localparam int IDX_W = 8;
  localparam int DATA_W = 16;
  localparam int EE_WORDS = 256;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_KEY = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PAGE = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_TOFS = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_TWR = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_TRD = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_STAT = 12'h018;

  localparam int B_GO = 15;
  localparam int B_PERMIT = 14;
  localparam int B_ABORT = 13;
  localparam int B_SKIP = 12;
  localparam int B_ERASE = 6;
  localparam int B_OP_MSB = 5;
  localparam int B_DONE = 0;
  localparam int B_BUSY = 1;

  localparam logic [5:0] OP_ERS8 = 6'h1a;
  localparam logic [5:0] OP_ERS4 = 6'h19;
  localparam logic [5:0] OP_ERS1 = 6'h18;
  localparam logic [3:0] OP_BULK_TOP = 4'h4;
  localparam logic [3:0] OP_PGM_TOP = 4'h2;

  localparam logic [8:0] N_ONE = 9'h001;
  localparam logic [8:0] N_FOUR = 9'h004;
  localparam logic [8:0] N_EIGHT = 9'h008;
  localparam logic [8:0] N_BULK = 9'h100;

  localparam logic [7:0] KEY1 = 8'h55;
  localparam logic [7:0] KEY2 = 8'haa;
  localparam logic [23:0] EE_BASE = 24'h7ffe00;
  localparam logic [23:0] EE_LAST = 24'h7fffff;
  localparam logic [DATA_W-1:0] ERASED = 16'hffff;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ERS_WAIT, ST_ERS_SWEEP, ST_PGM_WAIT, ST_PGM_WR, ST_FIN
  } dee_state_t;

  typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_OPEN} dee_ul_t;

endpackage : dee_pkg

`default_nettype wire

// File: rtl/dee_unlock.sv
// two-write key sequence detector guarding the control register
// assumes access pulses once per completed apb transfer
`default_nettype none

module dee_unlock
  import dee_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic access,
  input wire logic key_wr,
  input wire logic [7:0] key_val,
  output logic unlocked
);

  dee_ul_t st_q;
  logic k1;
  logic k2;

  assign k1 = key_wr && (key_val == KEY1);
  assign k2 = key_wr && (key_val == KEY2);

  // [R1] 55h then aa h, nothing between
  // [R2] window lasts one transfer only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= UL_IDLE;
    end else if (access) begin
      case (st_q)
        UL_HALF: st_q <= k2 ? UL_OPEN : (k1 ? UL_HALF : UL_IDLE);
        default: st_q <= k1 ? UL_HALF : UL_IDLE;
      endcase
    end
  end

  assign unlocked = (st_q == UL_OPEN);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_first_key;
    access && k1;
  endsequence

  sequence s_second_key;
    access && k2 && (st_q == UL_HALF);
  endsequence

  key_pair_a: assert property (s_second_key |=> unlocked) // [R1]
    else $error("key pair did not unlock");
  key_order_a: assert property ($rose(unlocked) |-> $past(k2)) // [R1]
    else $error("unlock without second key");
  half_step_a: assert property (s_first_key |=> !unlocked) // [R1]
    else $error("first key alone unlocked");
  one_shot_a: assert property (unlocked && access |=> !unlocked) // [R2]
    else $error("unlock window outlived one transfer");

endmodule : dee_unlock

`default_nettype wire

// File: sim/dee_ctrl_bench.sv
// self-checking bench of the data eeprom controller, driven over apb
// assumes zero-wait apb slave; erase and program waits shortened to 4
`default_nettype none

module dee_ctrl_bench
  import dee_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic external_reset_pin_n, watchdog_rst, nv_done_irq_flag, last_err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [5:0] ops [3];
  logic [15:0] ew;
  int cnt [3];
  int fail_count, cmp_count, timeout_q;

  dee_ctrl #(.ERS_CYC(4), .PGM_CYC(4), .WORDS(EE_WORDS)) dee_ctrl_i (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(external_reset_pin_n),
    .watchdog_rst(watchdog_rst), .nv_done_irq_flag(nv_done_irq_flag)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // a hang anywhere counts as a mismatch
  always @(posedge core_clk) begin
    timeout_q <= timeout_q + 1;
    if (timeout_q == 30000) begin
      fail_count = fail_count + 1;
      conclude();
    end
  end

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // request held until pready is sampled high
  task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(string n, logic [ADDR_W-1:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask : rchk

  task automatic start(logic [31:0] c);
    wr(OFS_KEY, {24'h0, KEY1});
    wr(OFS_KEY, {24'h0, KEY2});
    wr(OFS_CTRL, c);
    repeat (2) @(posedge core_clk);
  endtask : start

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CTRL, 32'h0);
      n = n + 1;
    end while (rdat[B_GO] !== 1'b0 && n < 200);
    chk("go cleared", 32'h0, {31'h0, rdat[B_GO]});
  endtask : wait_idle

  task automatic tw(logic [7:0] pg, logic [15:0] ofs, logic [15:0] d);
    wr(OFS_PAGE, {24'h0, pg});
    wr(OFS_TOFS, {16'h0, ofs});
    wr(OFS_TWR, {16'habcd, d});
  endtask : tw

  task automatic pgm(logic [7:0] pg, int i, logic [15:0] d, logic s);
    tw(pg, 16'hfe00 + 16'(i * 2), d);
    start(32'hc008 | (s ? 32'h1000 : 32'h0));
    wait_idle();
  endtask : pgm

  // called only once go has cleared
  task automatic peek(string n, int i, logic [15:0] e);
    wr(OFS_TOFS, 32'hfe00 + 32'(i * 2));
    rchk(n, OFS_TRD, {16'h0, e});
  endtask : peek

  //////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    external_reset_pin_n = 1'b1;
    watchdog_rst = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    timeout_q = 0;
    ops = '{OP_ERS1, OP_ERS4, OP_ERS8};
    cnt = '{1, 4, 8};
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    rchk("ctrl reset", OFS_CTRL, 32'h0);
    wr(OFS_KEY, {24'h0, KEY1});
    rchk("key readback", OFS_KEY, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, last_err});
    // go refused unless unlock is immediately before
    wr(OFS_CTRL, 32'hc058);
    rchk("no unlock", OFS_CTRL, 32'h4058);
    wr(OFS_KEY, {24'h0, KEY1});
    wr(OFS_KEY, {24'h0, KEY2});
    rchk("status idle", OFS_STAT, 32'h0);
    wr(OFS_CTRL, 32'hc058);
    rchk("gap after key", OFS_CTRL, 32'h4058);
    wr(OFS_KEY, {24'h0, KEY2});
    wr(OFS_KEY, {24'h0, KEY1});
    wr(OFS_CTRL, 32'hc058);
    rchk("keys reversed", OFS_CTRL, 32'h4058);
    pgm(8'h7f, 3, 16'h5a3c, 1'b1);
    peek("program skip", 3, 16'h5a3c);
    rchk("ctrl after", OFS_CTRL, 32'h1008);
    chk("done pin", 32'h1, {31'h0, nv_done_irq_flag});
    rchk("done flag", OFS_STAT, 32'h1);
    rchk("latch low word", OFS_TWR, 32'h5a3c);
    pgm(8'h7f, 3, 16'h0ff0, 1'b1);
    peek("no pre-erase", 3, 16'h0a30);
    pgm(8'h7f, 3, 16'h1234, 1'b0);
    peek("pre-erase", 3, 16'h1234);
    // odd offset and page top bit are dropped by the capture
    tw(8'h7f, 16'hfe09, 16'h00ff);
    start(32'hd008);
    wait_idle();
    peek("odd offset", 4, 16'h00ff);
    pgm(8'hff, 6, 16'h0f0f, 1'b1);
    peek("page top bit", 6, 16'h0f0f);
    pgm(8'h7e, 8, 16'h0000, 1'b1);
    peek("outside array", 8, 16'hffff);
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 9; j++) begin
        pgm(8'h7f, 40 + 16 * k + j, 16'h0, 1'b1);
      end
      wr(OFS_STAT, 32'h1);
      tw(8'h7f, 16'hfe00 + 16'((40 + 16 * k) * 2), 16'h0);
      start(32'hc040 | {26'h0, ops[k]});
      if (k == 2) begin
        rchk("go while busy", OFS_CTRL, 32'hc05a);
        wr(OFS_PAGE, 32'h0000_0033);
        rchk("busy status", OFS_STAT, 32'h2);
        rchk("page while busy", OFS_PAGE, 32'h0000_0033);
      end
      wait_idle();
      for (int j = 0; j < 9; j++) begin
        ew = (j < cnt[k]) ? 16'hffff : 16'h0000;
        peek("erase run", 40 + 16 * k + j, ew);
      end
    end
    pgm(8'h7f, 255, 16'h0, 1'b1);
    tw(8'h00, 16'h0000, 16'h0);
    start(32'hc052);
    wait_idle();
    peek("bulk low", 3, 16'hffff);
    peek("bulk top", 255, 16'hffff);
    // a write code outside the decode finishes at once
    wr(OFS_STAT, 32'h1);
    start(32'hc000);
    wait_idle();
    rchk("no-op done", OFS_STAT, 32'h1);
    peek("no-op keeps", 3, 16'hffff);
    // abort from each reset source during an eight word erase
    for (int s = 0; s < 2; s++) begin
      wr(OFS_STAT, 32'h1);
      tw(8'h7f, 16'hfe00, 16'h0);
      start(32'hc05a);
      watchdog_rst <= (s == 0);
      external_reset_pin_n <= (s == 0);
      repeat (4) @(posedge core_clk);
      watchdog_rst <= 1'b0;
      external_reset_pin_n <= 1'b1;
      wait_idle();
      rchk("abort ctrl", OFS_CTRL, 32'h205a);
      rchk("abort no done", OFS_STAT, 32'h0);
    end
    pgm(8'h7f, 9, 16'h4321, 1'b1);
    rchk("abort cleared", OFS_CTRL, 32'h1008);
    conclude();
  end
endmodule : dee_ctrl_bench

`default_nettype wire
